// ### common/wwdt_pkg.sv
package wwdt_pkg;

    // counter geometry
    localparam int CNT_W = 16;
    localparam logic [15:0] CNT_MAX = 16'hFFFF;

    // prescaler factors
    localparam int DIV_SLOW = 16384;
    localparam int DIV_FAST = 256;

    // default interval, derived from wake-up oscillator rate
    localparam int WU_FREQ_KHZ = 500;
    localparam int DEF_INTERVAL_US = 130000;
    localparam int DEF_TICKS = (DEF_INTERVAL_US * WU_FREQ_KHZ / 1000 + DIV_FAST / 2) / DIV_FAST;
    localparam logic [15:0] RELOAD_RST = 16'(17'h10000 - 17'(DEF_TICKS));

    // register byte offsets
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_RELOAD = 4'h4;
    localparam logic [3:0] OFS_WINDOW = 4'h8;
    localparam logic [3:0] OFS_STATUS = 4'hC;

    // field positions
    localparam int CTRL_CLK_SEL_BIT = 0;
    localparam int CTRL_DIV_SEL_BIT = 1;
    localparam int STAT_EN_BIT = 16;
    localparam int STAT_PEND_BIT = 17;
    localparam int STAT_OVF_BIT = 18;
    localparam int STAT_EARLY_BIT = 19;

    // reset values
    localparam logic CLK_SEL_RST = 1'h1;
    localparam logic DIV_SEL_RST = 1'h1;
    localparam logic [15:0] WINDOW_RST = 16'h0000;

    // bus encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'h0;

    // clock source and divider choice
    typedef struct packed {
        logic div_sel;
        logic clk_sel;
    } wwdt_ctrl_t;

    // service, start and stop pulses from the core
    typedef struct packed {
        logic service;
        logic start;
        logic stop;
    } wwdt_instr_t;

    // ahb-lite address phase
    typedef struct packed {
        logic hsel;
        logic [1:0] htrans;
        logic [31:0] haddr;
        logic hwrite;
        logic [2:0] hsize;
    } wwdt_ahb_t;

endpackage : wwdt_pkg

// ### logic/wwdt_prescaler.sv
`timescale 1ns/1ns
module wwdt_prescaler #(
    parameter int SLOW_DIV = wwdt_pkg::DIV_SLOW,
    parameter int FAST_DIV = wwdt_pkg::DIV_FAST
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire wwdt_pkg::wwdt_ctrl_t ctrl,
    input wire logic clear,
    input wire logic wakeup_osc_clock,
    output logic tick
);
    import wwdt_pkg::*;

    localparam int DW = $clog2(SLOW_DIV);
    localparam logic [DW-1:0] SLOW_LIM = DW'(SLOW_DIV - 1);
    localparam logic [DW-1:0] FAST_LIM = DW'(FAST_DIV - 1);

    typedef struct packed {
        logic sync1;
        logic sync2;
        logic osc_prev;
        logic [DW-1:0] div_cnt;
        logic tick;
    } wwdt_psc_state_t;

    wwdt_psc_state_t s_q;
    wwdt_psc_state_t s_d;
    logic src_en;
    logic [DW-1:0] limit;

    // sync the oscillator, pick source edge and divide
    always_comb begin
        s_d = s_q;
        s_d.sync1 = wakeup_osc_clock;
        s_d.sync2 = s_q.sync1;
        s_d.osc_prev = s_q.sync2;
        src_en = ctrl.clk_sel ? (s_q.sync2 & ~s_q.osc_prev) : 1'h1;
        limit = ctrl.div_sel ? FAST_LIM : SLOW_LIM;
        s_d.tick = 1'h0;
        if (clear) begin
            s_d.div_cnt = '0;
        end else if (src_en) begin
            if (s_q.div_cnt >= limit) begin
                s_d.div_cnt = '0;
                s_d.tick = 1'h1;
            end else begin
                s_d.div_cnt = s_q.div_cnt + DW'(1);
            end
        end
    end

    // state register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tick = s_q.tick;

endmodule : wwdt_prescaler

// ### logic/wwdt_top.sv
// Added by the designer: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ns
module wwdt_top (
    input wire logic hclk,
    input wire logic hresetn,
    input wire wwdt_pkg::wwdt_ahb_t ahb,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire wwdt_pkg::wwdt_instr_t instr,
    input wire logic wakeup_osc_clock,
    output logic reset_req,
    input wire logic reset_ack
);
    import wwdt_pkg::*;

    typedef struct packed {
        wwdt_ctrl_t ctrl;
        logic [15:0] reload;
        logic [15:0] window;
        logic [15:0] count;
        logic enabled;
        logic pending;
        logic cause_ovf;
        logic cause_early;
        logic wr_pend;
        logic [3:0] wr_addr;
        logic [31:0] rdata;
        logic cfg_written;
        logic cmd_seen;
    } wwdt_state_t;

    wwdt_state_t s_q;
    wwdt_state_t s_d;
    logic tick;
    logic psc_clear;
    logic acc;
    logic mapped;

    // service counts as early while the count is below the boundary
    function automatic logic is_early(input logic [15:0] cnt, input logic [15:0] bound);
        is_early = cnt < bound;
    endfunction : is_early

    // status word layout
    function automatic logic [31:0] status_word(input wwdt_state_t st);
        logic [31:0] w;
        w = '0;
        w[15:0] = st.count;
        w[STAT_EN_BIT] = st.enabled;
        w[STAT_PEND_BIT] = st.pending;
        w[STAT_OVF_BIT] = st.cause_ovf;
        w[STAT_EARLY_BIT] = st.cause_early;
        status_word = w;
    endfunction : status_word

    // count clock from selected source and divider
    wwdt_prescaler #(
        .SLOW_DIV(DIV_SLOW),
        .FAST_DIV(DIV_FAST)
    ) u_psc (
        .hclk(hclk),
        .hresetn(hresetn),
        .ctrl(s_q.ctrl),
        .clear(psc_clear),
        .wakeup_osc_clock(wakeup_osc_clock),
        .tick(tick)
    );

    // bus decode, register access, instructions and counter
    always_comb begin
        s_d = s_q;
        psc_clear = 1'h0;
        acc = ahb.hsel && hready && (ahb.htrans == HTRANS_NONSEQ);
        mapped = (ahb.haddr[31:4] == 28'h0000000) && (ahb.haddr[1:0] == 2'h0);

        // address phase: capture write target, prepare read data
        s_d.wr_pend = acc && ahb.hwrite && mapped;
        s_d.wr_addr = ahb.haddr[3:0];
        s_d.rdata = '0;
        if (acc && !ahb.hwrite && mapped) begin
            unique case (ahb.haddr[3:0])
                OFS_CTRL: begin
                    s_d.rdata[CTRL_CLK_SEL_BIT] = s_q.ctrl.clk_sel;
                    s_d.rdata[CTRL_DIV_SEL_BIT] = s_q.ctrl.div_sel;
                end
                OFS_RELOAD: s_d.rdata[15:0] = s_q.reload;
                OFS_WINDOW: s_d.rdata[15:0] = s_q.window;
                OFS_STATUS: s_d.rdata = status_word(s_q);
                default: s_d.rdata = '0;
            endcase
        end

        // data phase: apply write
        if (s_q.wr_pend) begin
            unique case (s_q.wr_addr)
                OFS_CTRL: begin
                    s_d.ctrl.clk_sel = hwdata[CTRL_CLK_SEL_BIT];
                    s_d.ctrl.div_sel = hwdata[CTRL_DIV_SEL_BIT];
                    s_d.cfg_written = 1'h1;
                end
                OFS_RELOAD: begin
                    s_d.reload = hwdata[15:0];
                    s_d.cfg_written = 1'h1;
                end
                OFS_WINDOW: begin
                    s_d.window = hwdata[15:0];
                    s_d.cfg_written = 1'h1;
                end
                OFS_STATUS: begin
                    if (hwdata[STAT_OVF_BIT]) begin
                        s_d.cause_ovf = 1'h0;
                    end
                    if (hwdata[STAT_EARLY_BIT]) begin
                        s_d.cause_early = 1'h0;
                    end
                end
                default: s_d.cfg_written = s_q.cfg_written;
            endcase
        end

        // start and stop take effect at once, start wins a tie
        if (instr.stop) begin
            s_d.enabled = 1'h0;
            s_d.cmd_seen = 1'h1;
        end
        if (instr.start) begin
            s_d.enabled = 1'h1;
            s_d.cmd_seen = 1'h1;
        end

        // watchdog events; causes set after the clear so set wins
        if (s_q.pending) begin
            if (reset_ack) begin
                s_d.pending = 1'h0;
                s_d.count = s_q.reload;
                psc_clear = 1'h1;
            end
        end else if (instr.service) begin
            if (s_q.enabled && is_early(s_q.count, s_q.window)) begin
                s_d.pending = 1'h1;
                s_d.cause_early = 1'h1;
            end else begin
                s_d.count = s_q.reload;
                psc_clear = 1'h1;
            end
        end else if (s_q.enabled && tick) begin
            if (s_q.count == CNT_MAX) begin
                s_d.pending = 1'h1;
                s_d.cause_ovf = 1'h1;
            end else begin
                s_d.count = s_q.count + 16'h0001;
            end
        end
    end

    // state register, enabled with default setup after reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q <= '0;
            s_q.ctrl.clk_sel <= CLK_SEL_RST;
            s_q.ctrl.div_sel <= DIV_SEL_RST;
            s_q.reload <= RELOAD_RST;
            s_q.count <= RELOAD_RST;
            s_q.window <= WINDOW_RST;
            s_q.enabled <= 1'h1;
        end else begin
            s_q <= s_d;
        end
    end

    // bus answers and reset request
    assign hreadyout = 1'h1;
    assign hresp = HRESP_OKAY;
    assign hrdata = s_q.rdata;
    assign reset_req = s_q.pending;

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    property p_enabled_until_cmd;
        !s_q.cmd_seen |-> s_q.enabled;
    endproperty
    a_enabled_until_cmd: assert property (p_enabled_until_cmd)
        else $error("watchdog not enabled before any stop");

    property p_stop_now;
        (instr.stop && !instr.start) |=> !s_q.enabled;
    endproperty
    a_stop_now: assert property (p_stop_now)
        else $error("stop did not disable next cycle");

    property p_start_now;
        instr.start |=> s_q.enabled;
    endproperty
    a_start_now: assert property (p_start_now)
        else $error("start did not enable next cycle");

    property p_overflow_req;
        (s_q.enabled && !s_q.pending && !instr.service && tick && s_q.count == CNT_MAX)
            |=> (reset_req && s_q.cause_ovf);
    endproperty
    a_overflow_req: assert property (p_overflow_req)
        else $error("overflow did not raise reset request");

    property p_early_req;
        (s_q.enabled && !s_q.pending && instr.service && is_early(s_q.count, s_q.window))
            |=> (reset_req && s_q.cause_early && $stable(s_q.count));
    endproperty
    a_early_req: assert property (p_early_req)
        else $error("early service did not raise reset request");

    property p_count_steps;
        (!s_q.pending && !instr.service && s_q.enabled && tick && s_q.count != CNT_MAX)
            |=> (s_q.count == $past(s_q.count) + 16'h0001);
    endproperty
    a_count_steps: assert property (p_count_steps)
        else $error("counter did not step by one on tick");

    property p_service_reload;
        (!s_q.pending && instr.service && !(s_q.enabled && is_early(s_q.count, s_q.window)))
            |=> (s_q.count == $past(s_q.reload) && !reset_req);
    endproperty
    a_service_reload: assert property (p_service_reload)
        else $error("valid service did not load reload value");

    property p_default_setup;
        !s_q.cfg_written |-> (s_q.ctrl.clk_sel == CLK_SEL_RST && s_q.ctrl.div_sel == DIV_SEL_RST
            && s_q.reload == RELOAD_RST);
    endproperty
    a_default_setup: assert property (p_default_setup)
        else $error("default setup lost before software change");

    property p_req_held;
        (reset_req && !reset_ack) |=> (reset_req && $stable(s_q.count));
    endproperty
    a_req_held: assert property (p_req_held)
        else $error("reset request dropped without acknowledge");

    property p_no_stall;
        (acc && !ahb.hwrite) |=> hreadyout && (hresp == HRESP_OKAY)
            && (hrdata == 32'h0 || $past(mapped));
    endproperty
    a_no_stall: assert property (p_no_stall)
        else $error("bus answer not ready and okay");

    // release, hold, no-request and bus read and write checks
    property p_ack_release;
        (reset_req && reset_ack) |=> (!reset_req && s_q.count == $past(s_q.reload));
    endproperty
    a_ack_release: assert property (p_ack_release)
        else $error("acknowledge did not release and reload");

    property p_pending_ignores;
        (s_q.pending && !reset_ack && !(s_q.wr_pend && s_q.wr_addr == OFS_STATUS))
            |=> ($stable(s_q.cause_ovf) && $stable(s_q.cause_early));
    endproperty
    a_pending_ignores: assert property (p_pending_ignores)
        else $error("watchdog event taken while request pending");

    property p_hold_disabled;
        (!s_q.enabled && !s_q.pending && !instr.service) |=> $stable(s_q.count);
    endproperty
    a_hold_disabled: assert property (p_hold_disabled)
        else $error("stopped counter moved");

    property p_stopped_quiet;
        (!s_q.enabled && !s_q.pending) |=> !reset_req;
    endproperty
    a_stopped_quiet: assert property (p_stopped_quiet)
        else $error("stopped watchdog raised a request");

    property p_no_req_without_event;
        (!s_q.pending && !(s_q.enabled && tick && s_q.count == CNT_MAX)
            && !(instr.service && s_q.enabled && is_early(s_q.count, s_q.window))) |=> !reset_req;
    endproperty
    a_no_req_without_event: assert property (p_no_req_without_event)
        else $error("reset request without overflow or early service");

    property p_reload_write;
        (s_q.wr_pend && s_q.wr_addr == OFS_RELOAD)
            |=> ({16'h0000, s_q.reload} == ($past(hwdata) & 32'h0000FFFF));
    endproperty
    a_reload_write: assert property (p_reload_write)
        else $error("reload write did not land");

    property p_rdata_idle;
        !(acc && !ahb.hwrite) |=> (hrdata == 32'h0);
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data not zero outside data phase");

    property p_cause_clear;
        (s_q.wr_pend && s_q.wr_addr == OFS_STATUS && hwdata[STAT_OVF_BIT]
            && !(s_q.enabled && tick && s_q.count == CNT_MAX)) |=> !s_q.cause_ovf;
    endproperty
    a_cause_clear: assert property (p_cause_clear)
        else $error("overflow cause not cleared by write");

    c_overflow: cover property (!reset_req ##1 reset_req && s_q.cause_ovf);
    c_early: cover property (!reset_req ##1 reset_req && s_q.cause_early);
    c_service: cover property (instr.service && !s_q.pending ##1 !reset_req);
    c_stop_start: cover property (instr.stop ##[1:20] instr.start);
    c_ack_release: cover property (reset_req && reset_ack ##1 !reset_req);

endmodule : wwdt_top

// ### test/test_window_watchdog_timer.sv
`timescale 1ns/1ns
module test_window_watchdog_timer;
    import wwdt_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    wwdt_ahb_t ahb = '0;
    wwdt_instr_t instr = '0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic [31:0] r;
    logic hreadyout, hresp, reset_req, reset_ack, osc;
    logic [7:0] ack_wait = 8'h28;
    int miscompares = 0;
    int check_count = 0;
    int cyc = 0;
    int n;
    int divs[3] = '{DIV_FAST, DIV_SLOW, DIV_FAST * (125000 / WU_FREQ_KHZ)};
    int slack[3] = '{4, 4, 260};
    logic [31:0] ctrls[3] = '{32'h2, 32'h0, 32'h3};

    wwdt_top dut (.hclk(hclk), .hresetn(hresetn), .ahb(ahb), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .instr(instr), .wakeup_osc_clock(osc), .reset_req(reset_req),
        .reset_ack(reset_ack));
    wwdt_partner partner (.hclk(hclk), .hresetn(hresetn), .reset_req(reset_req),
        .ack_wait(ack_wait), .reset_ack(reset_ack), .wakeup_osc_clock(osc));

    // 125 MHz bus clock
    always #4 hclk = ~hclk;

    // hang guard
    always @(posedge hclk) begin
        cyc = cyc + 1;
        if (cyc == 95000) begin
            miscompares++;
            test_done();
        end
    end

    task test_done;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : test_done

    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // one ahb-lite single transfer, waits on hready in both phases
    task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge hclk);
        ahb <= '{hsel: 1'b1, htrans: HTRANS_NONSEQ, haddr: a, hwrite: w, hsize: 3'h2};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        ahb <= '0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask : bus

    task rd(input logic [3:0] a, input logic [31:0] exp);
        bus(1'b0, {28'h0, a}, 32'h0);
        chk(r, exp);
    endtask : rd

    task wr(input logic [3:0] a, input logic [31:0] d);
        bus(1'b1, {28'h0, a}, d);
    endtask : wr

    // one-cycle instruction pulse: 4 service, 2 start, 1 stop
    task pulse(input logic [2:0] k);
        @(posedge hclk);
        instr <= k;
        @(posedge hclk);
        instr <= '0;
    endtask : pulse

    task wait_req(input logic lv);
        while (reset_req !== lv) @(posedge hclk);
    endtask : wait_req

    initial begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        // defaults after reset
        rd(OFS_CTRL, 32'h3);
        rd(OFS_RELOAD, 32'hFF02);
        rd(OFS_STATUS, 32'h0001FF02);
        bus(1'b0, 32'h10, 32'h0);
        chk(r, 32'h0);
        $display("test defaults done");
        // service loads reload value
        wr(OFS_CTRL, 32'h2);
        wr(OFS_RELOAD, 32'hFFFC);
        pulse(3'h4);
        rd(OFS_STATUS, 32'h0001FFFC);
        $display("test reload done");
        // stop holds the count, start resumes
        pulse(3'h1);
        rd(OFS_STATUS, 32'h0000FFFC);
        repeat (600) @(posedge hclk);
        rd(OFS_STATUS, 32'h0000FFFC);
        pulse(3'h2);
        rd(OFS_STATUS, 32'h0001FFFC);
        $display("test stop start done");
        // overflow on each source and divider, service ignored while pending
        for (int i = 0; i < 3; i++) begin
            wr(OFS_RELOAD, 32'hFFFF);
            wr(OFS_CTRL, ctrls[i]);
            pulse(3'h4);
            n = 0;
            while (reset_req !== 1'b1) begin
                @(posedge hclk);
                n++;
            end
            chk(32'(n > divs[i] - slack[i] && n < divs[i] + 8), 32'h1);
            rd(OFS_STATUS, 32'h0007FFFF);
            pulse(3'h4);
            rd(OFS_STATUS, 32'h0007FFFF);
            wait_req(1'b0);
            rd(OFS_STATUS, 32'h0005FFFF);
            wr(OFS_STATUS, 32'h000C0000);
        end
        $display("test overflow done");
        // service inside the closed window
        wr(OFS_WINDOW, 32'hFFFE);
        wr(OFS_CTRL, 32'h2);
        wr(OFS_RELOAD, 32'hFFFC);
        pulse(3'h4);
        rd(OFS_STATUS, 32'h0001FFFC);
        pulse(3'h4);
        wait_req(1'b1);
        rd(OFS_STATUS, 32'h000BFFFC);
        wait_req(1'b0);
        wr(OFS_WINDOW, 32'h0);
        $display("test window done");
        // a reset after a stop brings the watchdog back enabled
        pulse(3'h1);
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        rd(OFS_STATUS, 32'h0001FF02);
        rd(OFS_CTRL, 32'h3);
        $display("test reset done");
        test_done();
    end
endmodule : test_window_watchdog_timer

// ### test/wwdt_partner.sv
`timescale 1ns/1ns
module wwdt_partner (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic reset_req,
    input wire logic [7:0] ack_wait,
    output logic reset_ack,
    output logic wakeup_osc_clock
);
    logic [7:0] wait_q;
    // quiet outputs from time zero
    initial begin
        wakeup_osc_clock = 1'b0;
        reset_ack = 1'b0;
    end
    // free-running wake-up oscillator at 500 kHz
    always #1000 wakeup_osc_clock = ~wakeup_osc_clock;
    // reset logic: acknowledge a pending request after ack_wait cycles
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wait_q <= 8'h00;
            reset_ack <= 1'b0;
        end else if (reset_req !== 1'b1) begin
            wait_q <= 8'h00;
            reset_ack <= 1'b0;
        end else if (wait_q >= ack_wait) begin
            reset_ack <= 1'b1;
        end else begin
            wait_q <= wait_q + 8'h01;
        end
    end
endmodule : wwdt_partner
